// ===== rtl/pibs_pkg.sv
/*
 Package for the pin I/O and band steering block: register map, field
 positions, reset values, structs and states.
 Assumes a single AHB-Lite slave with 32-bit data, word-aligned registers.
*/
`default_nettype none
package pibs_pkg;
    localparam logic [7:0] PIBS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PIBS_REF_ADDR = 8'h04;
    localparam logic [7:0] PIBS_CONV_ADDR = 8'h08;
    localparam logic [7:0] PIBS_COUNT_ADDR = 8'h0C;
    localparam logic [7:0] PIBS_STAT_ADDR = 8'h10;
    localparam logic [7:0] PIBS_REFCNT_ADDR = 8'h14;
    localparam logic [7:0] PIBS_LOOPCNT_ADDR = 8'h18;
    // Control byte word
    localparam int CTL_OUT_A = 0;
    localparam int CTL_OUT_B = 1;
    localparam int CTL_OUT_C = 2;
    localparam int CTL_READ_F = 3;
    localparam int CTL_CHAN = 4;
    localparam int CTL_READ_A = 6;
    localparam int CTL_SAMPLE = 7;
    // Reference configuration word
    localparam int REF_OUT_D = 0;
    localparam int REF_BAND = 1;
    localparam int REF_REJECT = 2;
    localparam int REF_STANDBY = 3;
    localparam logic [7:0] PIBS_CTRL_RST = 8'h00;
    localparam logic [7:0] PIBS_REF_RST = 8'h00;
    // Converter word layout
    localparam int CONV_IN_D = 0;
    localparam int CONV_IN_C = 1;
    localparam int CONV_RES_LSB = 2;
    localparam int CONV_RES_W = 6;
    // Count word layout
    localparam int CNT_W = 22;
    localparam int CNT_IN_D = 22;
    localparam int SHIFT_W = 24;
    localparam int DIV_W = 16;
    // Rejection integrator: accept below reference / 8
    localparam int REJ_DIV = 8;
    localparam int REJ_W = 4;
    localparam logic [REJ_W-1:0] REJ_MAX = 4'(REJ_DIV);
    localparam logic [REJ_W-1:0] REJ_ZERO = 4'h0;
    localparam logic [REJ_W-1:0] REJ_HALF = 4'(REJ_DIV / 2);

    typedef struct packed {
        logic out_a;
        logic out_b;
        logic out_c;
        logic out_d;
    } pibs_gpo_t;

    typedef struct packed {
        logic in_a;
        logic in_b;
    } pibs_ain_t;

    typedef enum logic [1:0] {PIBS_IDLE, PIBS_DATA_RD, PIBS_DATA_WR} pibs_bus_t;
endpackage
`default_nettype wire

// ===== rtl/pibs_top.sv
/*
 Pin I/O and band steering: GPIO, converter channel mux, band steering of
 counter and loop divider clocks, rejection integrator and standby pin control.
 Assumes hclk is faster than twice any sampled pin rate; all pins are
 synchronised; AHB-Lite slave whose hreadyout is the bus hready.
*/
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`default_nettype none
module pibs_top
    import pibs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic in_c_pin,
    input wire logic in_d_pin,
    output logic out_a_o,
    output logic out_a_oe,
    output logic out_b_o,
    output logic out_c_o,
    output logic out_d_o,
    input wire pibs_ain_t analog_in,
    output logic conv_select,
    input wire logic [5:0] conv_result,
    output logic conv_sample,
    input wire logic [21:0] freq_count,
    input wire logic reference_osc_input,
    input wire logic low_band_if_input,
    input wire logic high_band_if_input,
    input wire logic low_band_loop_input,
    input wire logic high_band_loop_input,
    output logic buffered_reference_output,
    output logic buffered_reference_output_oe,
    output logic count_clk_en,
    output logic standby_pull_ref,
    output logic standby_pull_low_if,
    output logic standby_pull_high_loop,
    output logic standby_float_high_if,
    output logic standby_float_low_loop,
    input wire logic [15:0] ref_div_load,
    input wire logic [15:0] loop_div_load
);
    localparam int NSYNC = 7;
    // Bit positions in the synchroniser vector
    localparam int SY_IN_C = 6;
    localparam int SY_IN_D = 5;
    localparam int SY_REF = 4;
    localparam int SY_LOW_IF = 3;
    localparam int SY_HIGH_IF = 2;
    localparam int SY_LOW_LOOP = 1;
    localparam int SY_HIGH_LOOP = 0;

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] refcfg_r, refcfg_nxt;
    logic [SHIFT_W-1:0] shift_r, shift_nxt;
    logic [DIV_W-1:0] ref_div_r, loop_div_r;
    logic [REJ_W-1:0] rej_r;
    logic rej_out_r;
    logic [NSYNC-1:0] sync1_r, sync2_r, prev_r;
    logic [7:0] addr_r;
    logic wr_r;
    logic rd_r;

    // Two-stage synchronisers for every pin input
    wire [NSYNC-1:0] pins_raw = {in_c_pin, in_d_pin, reference_osc_input, low_band_if_input,
                                 high_band_if_input, low_band_loop_input, high_band_loop_input};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end
        else if (clk_en)
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    wire in_c = sync2_r[SY_IN_C];
    wire in_d = sync2_r[SY_IN_D];
    wire [NSYNC-1:0] rise = sync2_r & ~prev_r;
    wire ref_rise = rise[SY_REF];
    wire low_if_lvl = sync2_r[SY_LOW_IF];
    wire high_if_rise = rise[SY_HIGH_IF];
    wire low_loop_rise = rise[SY_LOW_LOOP];
    wire high_loop_rise = rise[SY_HIGH_LOOP];

    wire band_high = refcfg_r[REF_BAND];
    wire standby = refcfg_r[REF_STANDBY];
    wire reject_en = refcfg_r[REF_REJECT];

    // Integrator: counts up while high, down while low, every reference edge;
    // top rail at four edges, so only a half period of four reference periods
    // or more (below reference/8) reaches it; faster tones are dropped
    wire rej_up = ref_rise && low_if_lvl && (rej_r != REJ_HALF);
    wire rej_dn = ref_rise && !low_if_lvl && (rej_r != REJ_ZERO);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rej_r <= REJ_ZERO;
            rej_out_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rej_up)
                rej_r <= rej_r + 4'h1;
            else if (rej_dn)
                rej_r <= rej_r - 4'h1;
            if (rej_r == REJ_HALF)
                rej_out_r <= 1'b1;
            else if (rej_r == REJ_ZERO)
                rej_out_r <= 1'b0;
        end
    end

    logic low_if_prev_r;
    wire low_if_filt = reject_en ? rej_out_r : low_if_lvl;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            low_if_prev_r <= 1'b0;
        else if (clk_en)
            low_if_prev_r <= low_if_filt;
    end

    wire low_if_rise = low_if_filt && !low_if_prev_r;
    wire count_edge = band_high ? high_if_rise : low_if_rise;
    wire loop_edge = band_high ? high_loop_rise : low_loop_rise;

    // Reference and loop dividers reload on terminal count
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_div_r <= '0;
            loop_div_r <= '0;
        end
        else if (clk_en)
        begin
            if (ref_rise)
                ref_div_r <= (ref_div_r == '0) ? ref_div_load : ref_div_r - 16'h0001;
            if (loop_edge)
                loop_div_r <= (loop_div_r == '0) ? loop_div_load : loop_div_r - 16'h0001;
        end
    end

    // Bus decode
    // Address is registered every cycle; only trusted while wr_r or rd_r is high
    wire bus_req = hsel && hready && htrans[1];
    wire [7:0] a = addr_r;
    wire wr_ctrl = wr_r && (a == PIBS_CTRL_ADDR);
    wire wr_ref = wr_r && (a == PIBS_REF_ADDR);
    // Writes are inhibited while a read request is pending
    wire rd_pending = ctrl_r[CTL_READ_A] || ctrl_r[CTL_READ_F];
    wire rd_conv = rd_r && (a == PIBS_CONV_ADDR);
    wire rd_count = rd_r && (a == PIBS_COUNT_ADDR);

    wire [SHIFT_W-1:0] conv_word = {{(SHIFT_W-CONV_RES_W-2){1'b0}}, conv_result, in_c, in_d};
    wire [SHIFT_W-1:0] count_word = {1'b0, in_d, freq_count};

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        refcfg_nxt = refcfg_r;
        shift_nxt = shift_r;
        if (ctrl_r[CTL_READ_A])
            shift_nxt = conv_word;
        else if (ctrl_r[CTL_READ_F])
            shift_nxt = count_word;
        if (wr_ctrl && !rd_pending)
            ctrl_nxt = hwdata[7:0];
        if (wr_ref && !rd_pending)
            refcfg_nxt = hwdata[7:0];
        // Read request self-clears once its word is read out
        if (rd_conv && ctrl_r[CTL_READ_A])
            ctrl_nxt[CTL_READ_A] = 1'b0;
        if (rd_count && ctrl_r[CTL_READ_F] && !ctrl_r[CTL_READ_A])
            ctrl_nxt[CTL_READ_F] = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= PIBS_CTRL_RST;
            refcfg_r <= PIBS_REF_RST;
            shift_r <= '0;
            addr_r <= '0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_r <= ctrl_nxt;
            refcfg_r <= refcfg_nxt;
            shift_r <= shift_nxt;
            addr_r <= haddr[7:0];
            wr_r <= bus_req && hwrite;
            rd_r <= bus_req && !hwrite;
        end
    end

    // Readback words are taken at the end of the first data-phase cycle
    logic [31:0] rdata;
    always_comb
    begin
        case (a)
            PIBS_CTRL_ADDR: rdata = {24'h000000, ctrl_r};
            PIBS_REF_ADDR: rdata = {24'h000000, refcfg_r};
            PIBS_CONV_ADDR: rdata = {8'h00, ctrl_r[CTL_READ_A] ? shift_r : conv_word};
            PIBS_COUNT_ADDR: rdata = {8'h00, (ctrl_r[CTL_READ_F] && !ctrl_r[CTL_READ_A]) ? shift_r : count_word};
            PIBS_STAT_ADDR: rdata = {26'h0000000, standby, band_high, rej_out_r, in_d, in_c, rd_pending};
            PIBS_REFCNT_ADDR: rdata = {16'h0000, ref_div_r};
            PIBS_LOOPCNT_ADDR: rdata = {16'h0000, loop_div_r};
            default: rdata = 32'h00000000;
        endcase
    end

    // Read data sampled into a flop so the data phase output is registered
    logic [31:0] hrdata_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= '0;
        else if (clk_en && bus_req && !hwrite)
            hrdata_r <= 32'h00000000;
        else if (clk_en && rd_r)
            hrdata_r <= rdata;
    end

    // Reads take one wait state so data comes from a flop
    logic rd_wait_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_wait_r <= 1'b0;
        else if (clk_en)
            rd_wait_r <= rd_r;
    end

    assign hrdata = hrdata_r;
    assign hreadyout = !(rd_r && !rd_wait_r) && clk_en;
    assign hresp = 1'b0;

    // Outputs keep their levels in standby
    // Output A only sinks; once released, the external pull-up sets its level
    assign out_a_o = 1'b0;
    assign out_a_oe = !ctrl_r[CTL_OUT_A];
    assign out_b_o = ctrl_r[CTL_OUT_B];
    assign out_c_o = ctrl_r[CTL_OUT_C];
    assign out_d_o = refcfg_r[REF_OUT_D];

    assign conv_select = ctrl_r[CTL_CHAN] ? analog_in.in_b : analog_in.in_a;
    assign conv_sample = ctrl_r[CTL_SAMPLE];
    assign count_clk_en = count_edge;

    // Output is P-channel open-drain: drives high only when enabled
    // Follows the synchronised level, so it lags the pin by two clocks
    assign buffered_reference_output = 1'b1;
    assign buffered_reference_output_oe = !band_high && !standby && sync2_r[4];

    // Standby steers the pad pulls and turns off the reference output; the logic keeps running
    assign standby_pull_ref = standby;
    assign standby_pull_low_if = standby;
    assign standby_pull_high_loop = standby;
    assign standby_float_high_if = standby;
    assign standby_float_low_loop = standby;
endmodule
`default_nettype wire

// ===== test/pibs_checker_assertions.sv
/*
 Checker for pibs_top: shadows the control and reference words from bus writes.
 Assumes hready is the slave's hreadyout and clk_en is held high.
*/
`default_nettype none
module pibs_checker
    import pibs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic out_a_o,
    input wire logic out_a_oe,
    input wire logic out_b_o,
    input wire logic out_c_o,
    input wire logic out_d_o,
    input wire pibs_ain_t analog_in,
    input wire logic conv_select,
    input wire logic buffered_reference_output_oe,
    input wire logic high_band_if_input,
    input wire logic count_clk_en
);
    logic pv_r, pw_r;
    logic [7:0] pa_r, ctl_r, ref_r;
    wire logic dend = pv_r & hready;
    wire logic wr_ok = dend & pw_r & ~(ctl_r[CTL_READ_A] | ctl_r[CTL_READ_F]);
    wire logic rd_end = dend & ~pw_r;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {pv_r, pw_r, pa_r} <= 10'h000;
        else if (hready)
            {pv_r, pw_r, pa_r} <= {hsel & htrans[1], hwrite, haddr[7:0]};
    // Read bits only gate writes, so slack on when they clear is harmless
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {ctl_r, ref_r} <= {PIBS_CTRL_RST, PIBS_REF_RST};
        else if (wr_ok && pa_r == PIBS_CTRL_ADDR)
            ctl_r <= hwdata[7:0];
        else if (wr_ok && pa_r == PIBS_REF_ADDR)
            ref_r <= hwdata[7:0];
        else if (rd_end && pa_r == PIBS_CONV_ADDR)
            ctl_r[CTL_READ_A] <= 1'b0;
        else if (rd_end && pa_r == PIBS_COUNT_ADDR && !ctl_r[CTL_READ_A])
            ctl_r[CTL_READ_F] <= 1'b0;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_out_a_drive: assert property (out_a_oe == !ctl_r[CTL_OUT_A] && !out_a_o)
        else $error("output A wrong");
    a_push_pull: assert property (out_b_o == ctl_r[CTL_OUT_B] && out_c_o == ctl_r[CTL_OUT_C])
        else $error("output B or C wrong");
    a_out_d_ref: assert property (out_d_o == ref_r[REF_OUT_D])
        else $error("output D wrong");
    a_reset_low: assert property ($rose(hresetn) |-> out_a_oe && !out_b_o && !out_c_o && !out_d_o)
        else $error("outputs not low after reset");
    a_chan_mux: assert property (conv_select == (ctl_r[CTL_CHAN] ? analog_in.in_b : analog_in.in_a))
        else $error("channel mux wrong");
    a_ref_off: assert property (ref_r[REF_BAND] [*2] |-> !buffered_reference_output_oe)
        else $error("reference driven in high band");
    a_cnt_band: assert property ((ref_r[REF_BAND] && !high_band_if_input) [*8] |-> !count_clk_en)
        else $error("count without high band edge");
    a_cnt_pulse: assert property (count_clk_en |=> !count_clk_en)
        else $error("count enable too long");
endmodule
bind pibs_top pibs_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .out_a_o, .out_a_oe, .out_b_o, .out_c_o, .out_d_o, .analog_in, .conv_select,
    .buffered_reference_output_oe, .high_band_if_input, .count_clk_en);
`default_nettype wire

// ===== test/pibs_radio_model.sv
/*
 Radio-side model: auxiliary inputs, converter and counter values, pin pulses.
 Assumes tb's clock; tb may change its static values.
*/
`default_nettype none
module pibs_radio_model
    import pibs_pkg::*;
(
    input wire logic hclk,
    output logic in_c_pin,
    output logic in_d_pin,
    output pibs_ain_t analog_in,
    output logic [5:0] conv_result,
    output logic [21:0] freq_count,
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {in_c_pin, in_d_pin, analog_in} = 4'hA;
        conv_result = 6'h2A;
        freq_count = 22'h155555;
        pins = 5'h00;
    end
    // Pins stand still between bursts; hold sets a prompt or slow pace
    task automatic pulse(input int sel, input int n, input int hold);
        repeat (n)
        begin
            pins[sel] <= 1'b1;
            repeat (hold) @(posedge hclk);
            pins[sel] <= 1'b0;
            repeat (hold) @(posedge hclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
 Testbench for pibs_top: AHB-Lite accesses and pin stimulus with expected values.
 Assumes the radio model and the bound checker.
*/
`default_nettype none
module tb
    import pibs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, oa, oa_oe, ob, oc, od, csel, csmp, cnt_en, bro, bro_oe, in_c_pin, in_d_pin;
    logic [4:0] pins;
    wire [4:0] stby;
    pibs_ain_t analog_in;
    logic [5:0] conv_result;
    logic [21:0] freq_count;
    int err_total = 0, num_checks = 0, cyc = 0, n_cnt = 0, k;
    always #50 hclk = ~hclk;
    always @(negedge hclk) if (cnt_en === 1'b1) n_cnt++;
    pibs_top i_dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .in_c_pin, .in_d_pin, .out_a_o(oa), .out_a_oe(oa_oe),
        .out_b_o(ob), .out_c_o(oc), .out_d_o(od), .analog_in, .conv_select(csel), .conv_result,
        .conv_sample(csmp), .freq_count, .reference_osc_input(pins[0]), .low_band_if_input(pins[1]),
        .high_band_if_input(pins[2]), .low_band_loop_input(pins[3]), .high_band_loop_input(pins[4]),
        .buffered_reference_output(bro), .buffered_reference_output_oe(bro_oe), .count_clk_en(cnt_en),
        .standby_pull_ref(stby[0]), .standby_pull_low_if(stby[1]), .standby_pull_high_loop(stby[2]),
        .standby_float_high_if(stby[3]), .standby_float_low_loop(stby[4]), .ref_div_load(16'h0100),
        .loop_div_load(16'h0100));
    pibs_radio_model i_radio (.hclk, .in_c_pin, .in_d_pin, .analog_in, .conv_result, .freq_count, .pins);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge hclk)
        if (++cyc == 4000)
        begin
            err_total++;
            complete_run();
        end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready is looked at mid-cycle, so it is the value the next edge samples
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        logic r;
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
        do
        begin
            @(negedge hclk) r = hreadyout;
            @(posedge hclk);
        end while (r !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do
        begin
            @(negedge hclk) {r, q} = {hreadyout, hrdata};
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(what, q, exp);
    endtask
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk) chk("reset pins", 32'({oa_oe, ob, oc, od, bro_oe, hresp}), 32'h20);
        @(posedge hclk);
        rd("ctrl reset", PIBS_CTRL_ADDR, 32'h0);
        rd("ref reset", PIBS_REF_ADDR, 32'h0);
        wr(PIBS_CTRL_ADDR, 32'h07);
        @(negedge hclk) chk("gpo set", 32'({oa_oe, ob, oc}), 32'h3);
        @(posedge hclk);
        wr(PIBS_CTRL_ADDR, 32'h92);
        wr(PIBS_REF_ADDR, 32'h01);
        @(negedge hclk) chk("gpo mix", 32'({oa_oe, ob, oc, od, csel, csmp}), 32'h35);
        @(posedge hclk);
        wr(PIBS_CTRL_ADDR, 32'h40);
        wr(PIBS_CTRL_ADDR, 32'h01);
        rd("ctrl locked", PIBS_CTRL_ADDR, 32'h40);
        rd("conv word", PIBS_CONV_ADDR, 32'hAA);
        rd("ctrl freed", PIBS_CTRL_ADDR, 32'h0);
        i_radio.in_d_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        wr(PIBS_CTRL_ADDR, 32'h08);
        rd("count word", PIBS_COUNT_ADDR, 32'h555555);
        k = n_cnt;
        i_radio.pulse(1, 3, 4);
        i_radio.pulse(2, 3, 5);
        chk("low band count", 32'(n_cnt - k), 32'h3);
        wr(PIBS_REF_ADDR, 32'h02);
        k = n_cnt;
        i_radio.pulse(1, 3, 4);
        i_radio.pulse(2, 2, 4);
        chk("high band count", 32'(n_cnt - k), 32'h2);
        wr(PIBS_REF_ADDR, 32'h00);
        i_radio.pins[0] <= 1'b1;
        repeat (6) @(posedge hclk);
        @(negedge hclk) chk("ref drive", 32'({bro, bro_oe}), 32'h3);
        @(posedge hclk);
        // Dividers start at zero and reload the tied value 0x100 on their first edge
        i_radio.pulse(0, 1, 4);
        rd("ref reload", PIBS_REFCNT_ADDR, 32'h100);
        i_radio.pulse(0, 3, 4);
        rd("ref divider", PIBS_REFCNT_ADDR, 32'hFD);
        i_radio.pulse(3, 1, 4);
        rd("loop reload", PIBS_LOOPCNT_ADDR, 32'h100);
        i_radio.pulse(4, 2, 4);
        i_radio.pulse(3, 3, 4);
        rd("loop low band", PIBS_LOOPCNT_ADDR, 32'hFD);
        wr(PIBS_REF_ADDR, 32'h02);
        i_radio.pulse(3, 2, 4);
        i_radio.pulse(4, 2, 6);
        rd("loop high band", PIBS_LOOPCNT_ADDR, 32'hFB);
        // Reference toggles every clock: slow tone passes, fast tone is dropped
        wr(PIBS_REF_ADDR, 32'h04);
        k = n_cnt;
        fork
            i_radio.pulse(0, 30, 1);
            i_radio.pulse(1, 2, 12);
        join
        chk("reject slow", 32'(n_cnt - k), 32'h2);
        k = n_cnt;
        fork
            i_radio.pulse(0, 30, 1);
            i_radio.pulse(1, 6, 4);
        join
        chk("reject fast", 32'(n_cnt - k), 32'h0);
        wr(PIBS_REF_ADDR, 32'h08);
        @(negedge hclk) chk("standby pins", 32'({stby, bro_oe}), 32'h3E);
        @(posedge hclk);
        rd("status", PIBS_STAT_ADDR, 32'h26);
        rd("unmapped", 8'h20, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
